// file: cmpi_pkg.sv
// Shared constants and carrier types for the chip mode and part identification block
package cmpi_pkg;

	// APB geometry
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;

	// Register indices; the byte address is four times the index
	localparam logic [9:0] IDX_PART_ID_HIGH = 10'h01A;
	localparam logic [9:0] IDX_PART_ID_LOW  = 10'h01B;
	localparam logic [9:0] IDX_MODE         = 10'h020;
	localparam logic [9:0] IDX_PAGE         = 10'h021;

	// Mode register fields
	localparam int unsigned MODE_NORMAL_BIT = 0;
	localparam int unsigned MODE_DEBUG_BIT  = 1;

	// Identification fields; values are arbitrary
	localparam logic [3:0]  ID_MAJOR_FAMILY = 4'h2;
	localparam logic [5:0]  ID_MINOR_FAMILY = 6'h0D;
	localparam logic [1:0]  ID_MAJOR_MASK   = 2'h1;
	localparam logic [3:0]  ID_MINOR_MASK   = 4'h2;
	localparam logic [15:0] PART_ID         = {ID_MAJOR_FAMILY, ID_MINOR_FAMILY, ID_MAJOR_MASK, ID_MINOR_MASK};

	// Program page window
	localparam int unsigned PAGE_W     = 4;
	localparam int unsigned WIN_OFS_W  = 14;
	localparam int unsigned GADDR_W    = 18;
	localparam logic [15:0] WIN_BASE   = 16'h8000;
	localparam logic [15:0] WIN_LAST   = 16'hBFFF;
	localparam logic [1:0]  GADDR_FILL = 2'h3;
	localparam logic [3:0]  PAGE_RESET = 4'h0;

	// Boot fetch addresses
	localparam logic [15:0] RESET_VECTOR_ADDR  = 16'hFFFE;
	localparam logic [15:0] MONITOR_ENTRY_ADDR = 16'hF000;

	// Start-up and mode states
	typedef enum logic [1:0] {
		ST_HOLD    = 2'b00,
		ST_NORMAL  = 2'b01,
		ST_SPECIAL = 2'b10
	} cmpi_mode_st_t;

	// APB request from the master
	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
		logic [3:0]        pstrb;
	} cmpi_apb_req_t;

	// APB answer to the master
	typedef struct packed {
		logic [DATA_W-1:0] prdata;
		logic              pready;
		logic              pslverr;
	} cmpi_apb_rsp_t;

endpackage

// file: cmpi_sync2.sv
// Two flip-flop synchroniser for the mode select pin
module cmpi_sync2 (
	// Clock
	input  wire logic clk,
	// Level in and out
	input  wire logic din,
	output wire logic dout
);
	typedef struct packed {
		logic [1:0] stage;
	} cmpi_sync_t;

	cmpi_sync_t sync_reg;
	cmpi_sync_t sync_next;

	// No reset: the pin must be tracked while the chip reset is held
	always_comb begin
		sync_next = '{stage: {sync_reg.stage[0], din}};
	end

	always_ff @(posedge clk) begin
		sync_reg <= sync_next;
	end

	assign dout = sync_reg.stage[1];
endmodule // cmpi_sync2

// file: cmpi_page_map.sv
// Translation of the local program window into the global address space
module cmpi_page_map (
	// Clock and reset
	input  wire logic                        clk,
	input  wire logic                        rst_n,
	// Page and local address
	input  wire logic [cmpi_pkg::PAGE_W-1:0] page,
	input  wire logic [15:0]                 local_addr,
	input  wire logic                        local_valid,
	// Translated address
	output wire logic [cmpi_pkg::GADDR_W-1:0] global_addr,
	output wire logic                         window_hit,
	output wire logic                         global_valid
);
	import cmpi_pkg::*;

	typedef struct packed {
		logic [GADDR_W-1:0] gaddr;
		logic               hit;
		logic               valid;
	} cmpi_map_t;

	cmpi_map_t map_reg;
	cmpi_map_t map_next;
	logic      in_win;

	always_comb begin
		in_win = (local_addr >= WIN_BASE) && (local_addr <= WIN_LAST);
		map_next.valid = local_valid;
		map_next.hit = local_valid && in_win;
		if (in_win) begin
			map_next.gaddr = {page, local_addr[WIN_OFS_W-1:0]};
		end else begin
			map_next.gaddr = {GADDR_FILL, local_addr};
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			map_reg <= '0;
		end else begin
			map_reg <= map_next;
		end
	end

	assign global_addr  = map_reg.gaddr;
	assign window_hit   = map_reg.hit;
	assign global_valid = map_reg.valid;

	chk_window_map: assert property (@(posedge clk) disable iff (!rst_n)
		(local_valid && local_addr >= WIN_BASE && local_addr <= WIN_LAST) |=>
		(window_hit && global_addr == {$past(page), $past(local_addr[WIN_OFS_W-1:0])}))
		else $error("window address not mapped through page");

	chk_window_miss: assert property (@(posedge clk) disable iff (!rst_n)
		(local_valid && (local_addr < WIN_BASE || local_addr > WIN_LAST)) |=> !window_hit)
		else $error("address outside window flagged as hit");
endmodule // cmpi_page_map

// file: cmpi_chip_config.sv
// Chip mode latch, part identification registers and program page window behind APB
module cmpi_chip_config (
	// Clock and reset
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	// APB slave
	input  wire cmpi_pkg::cmpi_apb_req_t       apb_req,
	output wire cmpi_pkg::cmpi_apb_rsp_t       apb_rsp,
	// Mode select pin
	input  wire logic                          mode_select,
	// Local program address from the core
	input  wire logic [15:0]                   local_addr,
	input  wire logic                          local_valid,
	// Global address out
	output wire logic [cmpi_pkg::GADDR_W-1:0]  global_addr,
	output wire logic                          window_hit,
	output wire logic                          global_valid,
	// Mode and boot control
	output wire logic                          mode_normal,
	output wire logic                          background_debug,
	output wire logic                          boot_strobe,
	output wire logic [15:0]                   boot_addr
);
	import cmpi_pkg::*;

	typedef struct packed {
		cmpi_mode_st_t     st;
		logic [PAGE_W-1:0] page;
		logic [DATA_W-1:0] prdata;
		logic              pready;
		logic              pslverr;
		logic              boot_strobe;
		logic [15:0]       boot_addr;
		logic              mode_normal;
		logic              debug_active;
	} cmpi_core_t;

	cmpi_core_t core_reg;
	cmpi_core_t core_next;

	logic       mode_sync;
	logic [9:0] word_idx;
	logic       setup_phase;
	logic       access_phase;
	logic       wr_lane0;
	logic       hit_id_high;
	logic       hit_id_low;
	logic       hit_mode;
	logic       hit_page;
	logic       mapped;

	// Pin is asynchronous to pclk
	cmpi_sync2 u_mode_sync (
		.clk  (pclk),
		.din  (mode_select),
		.dout (mode_sync)
	);

	cmpi_page_map u_page_map (
		.clk          (pclk),
		.rst_n        (presetn),
		.page         (core_reg.page),
		.local_addr   (local_addr),
		.local_valid  (local_valid),
		.global_addr  (global_addr),
		.window_hit   (window_hit),
		.global_valid (global_valid)
	);

	// Address decode
	always_comb begin
		word_idx     = apb_req.paddr[ADDR_W-1:2];
		setup_phase  = apb_req.psel && !apb_req.penable;
		access_phase = apb_req.psel && apb_req.penable && core_reg.pready;
		wr_lane0     = access_phase && apb_req.pwrite && apb_req.pstrb[0];
		hit_id_high  = (word_idx == IDX_PART_ID_HIGH);
		hit_id_low   = (word_idx == IDX_PART_ID_LOW);
		hit_mode     = (word_idx == IDX_MODE);
		hit_page     = (word_idx == IDX_PAGE);
		mapped       = hit_id_high || hit_id_low || hit_mode || hit_page;
	end

	always_comb begin
		core_next = core_reg;
		core_next.boot_strobe = 1'b0;
		core_next.pready = 1'b0;
		core_next.pslverr = 1'b0;

		// The synchroniser runs unreset, so its output already holds the pin level
		// sampled during reset; the first edge after release takes it.
		case (core_reg.st)
			ST_HOLD: begin
				if (mode_sync) begin
					core_next.st = ST_NORMAL;
					core_next.boot_addr = RESET_VECTOR_ADDR;
				end else begin
					core_next.st = ST_SPECIAL;
					core_next.boot_addr = MONITOR_ENTRY_ADDR;
				end
				core_next.boot_strobe = 1'b1;
			end
			ST_NORMAL: begin
				core_next.st = ST_NORMAL;
			end
			ST_SPECIAL: begin
				// Only the way out of special mode is open to software
				if (wr_lane0 && hit_mode && apb_req.pwdata[MODE_NORMAL_BIT]) begin
					core_next.st = ST_NORMAL;
				end
			end
			default: begin
				core_next.st = ST_HOLD;
			end
		endcase

		if (wr_lane0 && hit_page) begin
			core_next.page = apb_req.pwdata[PAGE_W-1:0];
		end

		core_next.mode_normal  = (core_next.st == ST_NORMAL);
		core_next.debug_active = (core_next.st == ST_SPECIAL);

		// Answer is built in the setup cycle so every bus output is a flip-flop;
		// the price is one fixed wait-free access phase.
		if (setup_phase) begin
			core_next.pready = 1'b1;
			core_next.pslverr = !mapped;
			core_next.prdata = '0;
			if (!apb_req.pwrite) begin
				if (hit_id_high) begin
					core_next.prdata[7:0] = PART_ID[15:8];
				end else if (hit_id_low) begin
					core_next.prdata[7:0] = PART_ID[7:0];
				end else if (hit_mode) begin
					core_next.prdata[MODE_NORMAL_BIT] = core_reg.mode_normal;
					core_next.prdata[MODE_DEBUG_BIT] = core_reg.debug_active;
				end else if (hit_page) begin
					core_next.prdata[PAGE_W-1:0] = core_reg.page;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_reg.st           <= ST_HOLD;
			core_reg.page         <= PAGE_RESET;
			core_reg.prdata       <= '0;
			core_reg.pready       <= 1'b0;
			core_reg.pslverr      <= 1'b0;
			core_reg.boot_strobe  <= 1'b0;
			core_reg.boot_addr    <= RESET_VECTOR_ADDR;
			core_reg.mode_normal  <= 1'b0;
			core_reg.debug_active <= 1'b0;
		end else begin
			core_reg <= core_next;
		end
	end

	assign apb_rsp.prdata    = core_reg.prdata;
	assign apb_rsp.pready    = core_reg.pready;
	assign apb_rsp.pslverr   = core_reg.pslverr;
	assign mode_normal       = core_reg.mode_normal;
	assign background_debug  = core_reg.debug_active;
	assign boot_strobe       = core_reg.boot_strobe;
	assign boot_addr         = core_reg.boot_addr;

	chk_id_high_read: assert property (@(posedge pclk) disable iff (!presetn)
		(setup_phase && !apb_req.pwrite && hit_id_high) |=>
		(apb_rsp.pready && !apb_rsp.pslverr && apb_rsp.prdata == {24'h000000, PART_ID[15:8]}))
		else $error("part id high byte read wrong");

	chk_id_low_read: assert property (@(posedge pclk) disable iff (!presetn)
		(setup_phase && !apb_req.pwrite && hit_id_low) |=>
		(apb_rsp.pready && apb_rsp.prdata == {24'h000000, PART_ID[7:0]}))
		else $error("part id low byte read wrong");

	chk_id_fields: assert property (@(posedge pclk) disable iff (!presetn)
		(setup_phase && !apb_req.pwrite && hit_id_low) |=>
		(apb_rsp.prdata[3:0] == ID_MINOR_MASK && apb_rsp.prdata[5:4] == ID_MAJOR_MASK
		&& apb_rsp.prdata[7:6] == ID_MINOR_FAMILY[1:0]))
		else $error("part id field layout wrong");

	chk_id_write_ignored: assert property (@(posedge pclk) disable iff (!presetn)
		(access_phase && apb_req.pwrite && (hit_id_high || hit_id_low)) |=>
		($stable(core_reg.page) && $stable(core_reg.st) && !apb_rsp.pslverr))
		else $error("write to part id had an effect");

	chk_mode_capture: assert property (@(posedge pclk) disable iff (!presetn)
		(core_reg.st == ST_HOLD) |=>
		(boot_strobe && mode_normal == $past(mode_sync) && background_debug == !$past(mode_sync)))
		else $error("mode select not captured at reset release");

	chk_mode_no_return: assert property (@(posedge pclk) disable iff (!presetn)
		(mode_normal && !boot_strobe) |=> (mode_normal && !background_debug)[*2])
		else $error("normal mode left by software");

	chk_mode_exit_write: assert property (@(posedge pclk) disable iff (!presetn)
		(core_reg.st == ST_SPECIAL && wr_lane0 && hit_mode && apb_req.pwdata[MODE_NORMAL_BIT]) |=>
		(mode_normal && !background_debug))
		else $error("special mode exit write not taken");

	chk_boot_vector: assert property (@(posedge pclk) disable iff (!presetn)
		(boot_strobe && mode_normal) |-> (boot_addr == RESET_VECTOR_ADDR))
		else $error("normal mode boot not from reset vector");

	chk_debug_monitor: assert property (@(posedge pclk) disable iff (!presetn)
		(boot_strobe && !mode_normal) |-> (background_debug && boot_addr == MONITOR_ENTRY_ADDR))
		else $error("special mode boot without debug monitor");

	chk_ready_timing: assert property (@(posedge pclk) disable iff (!presetn)
		setup_phase |=> (apb_rsp.pready ##1 !apb_rsp.pready))
		else $error("access phase not answered in one cycle");

	chk_unmapped_error: assert property (@(posedge pclk) disable iff (!presetn)
		(setup_phase && !mapped) |=> (apb_rsp.pslverr && apb_rsp.prdata == 32'h00000000))
		else $error("unmapped access not flagged");

	chk_page_write: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_lane0 && hit_page) |=> (core_reg.page == $past(apb_req.pwdata[PAGE_W-1:0])))
		else $error("page register write lost");

	chk_id_high_fields: assert property (@(posedge pclk) disable iff (!presetn)
		(setup_phase && !apb_req.pwrite && hit_id_high) |=>
		(apb_rsp.prdata[7:4] == ID_MAJOR_FAMILY && apb_rsp.prdata[3:0] == ID_MINOR_FAMILY[5:2]))
		else $error("part id high byte field layout wrong");

	chk_id_read_clean: assert property (@(posedge pclk) disable iff (!presetn)
		(setup_phase && !apb_req.pwrite && (hit_id_high || hit_id_low)) |=>
		(!apb_rsp.pslverr && apb_rsp.prdata[31:8] == 24'h000000))
		else $error("part id read not clean");

	chk_id_write_answer: assert property (@(posedge pclk) disable iff (!presetn)
		(setup_phase && apb_req.pwrite && (hit_id_high || hit_id_low)) |=>
		(apb_rsp.pready && !apb_rsp.pslverr))
		else $error("write to part id not answered cleanly");

	chk_special_flags: assert property (@(posedge pclk) disable iff (!presetn)
		(core_reg.st == ST_SPECIAL) |-> (background_debug && !mode_normal))
		else $error("special mode without background debug");

	chk_normal_flags: assert property (@(posedge pclk) disable iff (!presetn)
		(core_reg.st == ST_NORMAL) |-> (mode_normal && !background_debug))
		else $error("normal mode flags wrong");

	chk_normal_kept: assert property (@(posedge pclk) disable iff (!presetn)
		(core_reg.st == ST_NORMAL) |=> (core_reg.st == ST_NORMAL))
		else $error("normal mode left while running");

	chk_special_kept: assert property (@(posedge pclk) disable iff (!presetn)
		(core_reg.st == ST_SPECIAL && !(wr_lane0 && hit_mode && apb_req.pwdata[MODE_NORMAL_BIT])) |=>
		(core_reg.st == ST_SPECIAL))
		else $error("special mode left without exit write");

	chk_hold_left: assert property (@(posedge pclk) disable iff (!presetn)
		(core_reg.st == ST_HOLD) |=> (core_reg.st != ST_HOLD))
		else $error("mode not taken at first edge after reset");

	chk_strobe_single: assert property (@(posedge pclk) disable iff (!presetn)
		boot_strobe |=> !boot_strobe)
		else $error("boot strobe longer than one cycle");

	chk_boot_addr_kept: assert property (@(posedge pclk) disable iff (!presetn)
		(core_reg.st != ST_HOLD) |=> $stable(boot_addr))
		else $error("boot address moved after start-up");

	chk_mode_read: assert property (@(posedge pclk) disable iff (!presetn)
		(setup_phase && !apb_req.pwrite && hit_mode) |=>
		(apb_rsp.prdata == {30'h0, $past(background_debug), $past(mode_normal)}))
		else $error("mode register read wrong");

	chk_page_read: assert property (@(posedge pclk) disable iff (!presetn)
		(setup_phase && !apb_req.pwrite && hit_page) |=>
		(apb_rsp.prdata == {28'h0, $past(core_reg.page)}))
		else $error("page register read wrong");

	chk_page_strobe: assert property (@(posedge pclk) disable iff (!presetn)
		(access_phase && apb_req.pwrite && hit_page && !apb_req.pstrb[0]) |=>
		$stable(core_reg.page))
		else $error("page written without byte strobe");

	chk_ready_idle: assert property (@(posedge pclk) disable iff (!presetn)
		!apb_req.psel |=> !apb_rsp.pready)
		else $error("ready without a transfer");

	chk_error_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
		apb_rsp.pslverr |-> apb_rsp.pready)
		else $error("error flag outside access phase");

	chk_map_valid: assert property (@(posedge pclk) disable iff (!presetn)
		local_valid |=> global_valid)
		else $error("valid local address not passed on");

	chk_map_idle: assert property (@(posedge pclk) disable iff (!presetn)
		!local_valid |=> (!global_valid && !window_hit))
		else $error("idle local address flagged");

endmodule // cmpi_chip_config

// file: cmpi_strap_host.sv
// Board-side model that straps the mode select pin for the chip mode block
module cmpi_strap_host (
	// Clock
	input  wire logic pclk,
	// Boot mode asked for by the bench
	input  wire logic want_normal,
	// Mode select pin
	output logic      mode_select
);
	timeunit 1ns;
	timeprecision 1ps;

	initial mode_select = 1'b1;

	// Level moves only on a clock edge, so it follows want_normal at the first edge of the reset hold
	always @(posedge pclk) begin
		mode_select <= want_normal;
	end

endmodule // cmpi_strap_host

// file: test_chip_mode_and_part_id.sv
// Self-checking bench for the chip mode, part identification and page window block
module test_chip_mode_and_part_id import cmpi_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;

	logic                 pclk;
	logic                 presetn;
	logic                 mode_select;
	logic                 want_normal;
	logic                 local_valid;
	logic [15:0]          local_addr;
	cmpi_apb_req_t        apb_req;
	cmpi_apb_rsp_t        apb_rsp;
	logic [GADDR_W-1:0]   global_addr;
	logic                 window_hit;
	logic                 global_valid;
	logic                 mode_normal;
	logic                 background_debug;
	logic                 boot_strobe;
	logic [15:0]          boot_addr;
	logic [31:0]          rd;
	logic                 er;
	logic [15:0]          id;
	logic [3:0]           strb = 4'hF;
	int                   err_count = 0;
	int                   n_compared = 0;
	int                   cyc = 0;

	cmpi_chip_config dut_u (
		.pclk             (pclk),
		.presetn          (presetn),
		.apb_req          (apb_req),
		.apb_rsp          (apb_rsp),
		.mode_select      (mode_select),
		.local_addr       (local_addr),
		.local_valid      (local_valid),
		.global_addr      (global_addr),
		.window_hit       (window_hit),
		.global_valid     (global_valid),
		.mode_normal      (mode_normal),
		.background_debug (background_debug),
		.boot_strobe      (boot_strobe),
		.boot_addr        (boot_addr)
	);

	cmpi_strap_host strap_u (
		.pclk        (pclk),
		.want_normal (want_normal),
		.mode_select (mode_select)
	);

	always #12.5 pclk = ~pclk;

	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Ceiling is far above the fewer than a hundred cycles the tests need
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_count++;
			test_done();
		end
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One APB transfer, then one idle edge so no signal is assigned twice in a time step
	task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
		apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {idx, 2'b00}, pwdata: wd, pstrb: strb};
		@(posedge pclk);
		apb_req.penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (apb_rsp.pready !== 1'b1);
		rd = apb_rsp.prdata;
		er = apb_rsp.pslverr;
		apb_req <= '0;
		@(posedge pclk);
	endtask

	task automatic do_reset(input logic normal);
		presetn <= 1'b0;
		want_normal <= normal;
		repeat (5) @(posedge pclk);
		chk("mode in reset", 32'h0, {31'h0, mode_normal});
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		chk("boot strobe", 32'h1, {31'h0, boot_strobe});
		chk("mode normal", {31'h0, normal}, {31'h0, mode_normal});
		chk("debug active", {31'h0, ~normal}, {31'h0, background_debug});
		chk("boot addr", {16'h0, normal ? RESET_VECTOR_ADDR : MONITOR_ENTRY_ADDR}, {16'h0, boot_addr});
		@(posedge pclk);
		chk("boot strobe end", 32'h0, {31'h0, boot_strobe});
		$display("reset test done, normal=%0b", normal);
	endtask

	task automatic test_ident();
		apb(1'b0, IDX_PART_ID_HIGH, 32'h0);
		id[15:8] = rd[7:0];
		chk("id high err", 32'h0, {31'h0, er});
		apb(1'b0, IDX_PART_ID_LOW, 32'h0);
		id[7:0] = rd[7:0];
		chk("id word", {16'h0, PART_ID}, {16'h0, id});
		chk("major family", {28'h0, ID_MAJOR_FAMILY}, {28'h0, id[15:12]});
		chk("minor family", {26'h0, ID_MINOR_FAMILY}, {26'h0, id[11:6]});
		chk("major mask", {30'h0, ID_MAJOR_MASK}, {30'h0, id[5:4]});
		chk("minor mask", {28'h0, ID_MINOR_MASK}, {28'h0, id[3:0]});
		apb(1'b1, IDX_PART_ID_HIGH, 32'hFF);
		chk("id write err", 32'h0, {31'h0, er});
		apb(1'b0, IDX_PART_ID_HIGH, 32'h0);
		chk("id high kept", {24'h0, PART_ID[15:8]}, rd);
		apb(1'b1, IDX_PART_ID_LOW, 32'h00);
		apb(1'b0, IDX_PART_ID_LOW, 32'h0);
		chk("id low kept", {24'h0, PART_ID[7:0]}, rd);
		apb(1'b0, 10'h03F, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, er});
		chk("unmapped data", 32'h0, rd);
		$display("ident test done");
	endtask

	task automatic map(input logic [15:0] a, input logic hit, input logic [17:0] ga);
		local_addr <= a;
		local_valid <= 1'b1;
		repeat (2) @(posedge pclk);
		chk("window hit", {31'h0, hit}, {31'h0, window_hit});
		chk("global addr", {14'h0, ga}, {14'h0, global_addr});
		chk("global valid", 32'h1, {31'h0, global_valid});
	endtask

	task automatic test_page();
		apb(1'b1, IDX_PAGE, 32'h5);
		apb(1'b0, IDX_PAGE, 32'h0);
		chk("page readback", 32'h5, rd);
		strb = 4'hE;
		apb(1'b1, IDX_PAGE, 32'hA);
		strb = 4'hF;
		apb(1'b0, IDX_PAGE, 32'h0);
		chk("page strobe ignored", 32'h5, rd);
		map(16'h8123, 1'b1, 18'h14123);
		map(16'hBFFF, 1'b1, 18'h17FFF);
		map(16'h8000, 1'b1, 18'h14000);
		map(16'h7FFF, 1'b0, 18'h37FFF);
		map(16'hC000, 1'b0, 18'h3C000);
		$display("page test done");
	endtask

	task automatic test_mode();
		do_reset(1'b0);
		apb(1'b0, IDX_PAGE, 32'h0);
		chk("page reset", {28'h0, PAGE_RESET}, rd);
		apb(1'b0, IDX_MODE, 32'h0);
		chk("mode reg special", 32'h2, rd);
		apb(1'b1, IDX_MODE, 32'h1);
		@(posedge pclk);
		chk("mode switched", 32'h1, {31'h0, mode_normal});
		apb(1'b0, IDX_MODE, 32'h0);
		chk("mode reg normal", 32'h1, {30'h0, rd[1:0]});
		apb(1'b1, IDX_MODE, 32'h0);
		@(posedge pclk);
		chk("no switch back", 32'h1, {31'h0, mode_normal});
		$display("mode test done");
	endtask

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		want_normal = 1'b1;
		apb_req = '0;
		local_addr = 16'h0000;
		local_valid = 1'b0;
		@(posedge pclk);
		do_reset(1'b1);
		test_ident();
		test_page();
		test_mode();
		test_done();
	end

endmodule // test_chip_mode_and_part_id
